// *** pkg/eosc_pkg.sv ***
// Package for the ECU operation state control block.
// Assumes one 40 MHz core clock; all status inputs already synchronous.
package eosc_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP     = 3'h0,
    ST_RAMP_UP   = 3'h1,
    ST_NORMAL    = 3'h2,
    ST_AFTERRUN  = 3'h3,
    ST_AR_RESET  = 3'h4,
    ST_POWERDOWN = 3'h5,
    ST_WAKE_CLR  = 3'h6
  } eosc_state_t;

  // APB register offsets (byte addresses)
  localparam logic [7:0] OPERATION_CONFIG_REG_OFS = 8'h00;
  localparam logic [7:0] COMMAND_REG_OFS = 8'h04;
  localparam logic [7:0] OPERATION_STATUS_REG_OFS = 8'h08;

  // Config field positions
  localparam int CFG_AE_BIT = 0;
  localparam int CFG_AR_BIT = 1;
  localparam int CFG_MR_BIT = 2;
  // Command field positions
  localparam int CMD_WAKE_CLEAR_BIT_BIT = 0;
  // Status field positions
  localparam int STS_STATE_LSB = 0;
  localparam int STS_OM_BIT = 4;
  localparam int STS_WAKE_BIT = 5;

  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic CMD_WAKE_CLEAR_BIT_RESET = 1'h1;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic internal_pin_wake;
    logic bus_wake;
    logic engine_off_timer_wake;
  } eosc_wake_t;

  typedef struct packed {
    logic ramp_timer_overflow;
    logic powerdown_counter_overflow;
    logic secure_shutoff_timer_expired;
    logic powerdown_timer_overflow;
  } eosc_timer_t;

  typedef struct packed {
    logic main_relay_on;
    logic ecu_supply_en;
    logic tracker_en;
    logic pre_reg_en;
    logic ext_func_en;
    logic pd_timer_run;
    logic ramp_timer_run;
    logic wake_clear;
    logic wake_clear_mode;
    logic ar_reset;
  } eosc_ctrl_t;

  typedef struct packed {
    eosc_state_t state;
    logic afterrun_enable;
    logic afterrun_reset_enable;
    logic main_relay_status_bit;
    logic wake_clear_bit;
    logic relay_hold;
    logic [31:0] prdata;
    eosc_ctrl_t ctrl;
  } eosc_regs_t;

endpackage

// *** verilog/eosc_top.sv ***
// Operation state sequencer of an engine-management supply IC.
// Assumes all inputs synchronous to CORE_CLK_IN; RST_IN is the internal power-on reset.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

// How it works
// - Seven states: sleep, ramp up, normal, afterrun, afterrun reset, power-down, wake clear.
// - Sleep: relay off, ECU unsupplied; standby and wake circuits handled outside.
// - Ramp up: start own supplies, relay follows battery level.
// - Wake-started ramp must finish before ramp timer overflow.
// - Normal: whole ECU supplied, relay from battery level or status bit.
// - Afterrun: key low, afterrun enable set, ECU stays supplied.
// - Power-down: ECU supply and tracker off, pre-regulator on, timer runs, relay held, external functions off.
// - Wake clear: issue wake clear command in configured mode.
// - Power-on reset clears logic; exit to sleep or ramp up by key/wake.
// - Sleep to ramp up on key high or wake.
// - Ramp up to sleep when key low and no wake.
// - Ramp up to wake clear on key low, wake, ramp overflow.
// - Ramp up to normal when ECU supply good and key or wake.
// - Normal to afterrun on key low with afterrun enabled; config kept.
// - Normal or afterrun to sleep on enable clear, key low, no wake.
// - Power-down on counter overflow or shutoff expiry; normal needs key low.
// - Afterrun to normal on key high with afterrun reset clear.
// - Afterrun to afterrun reset on key high with afterrun reset set.
// - Afterrun reset leaves to normal on next clock.
// - Power-down to wake clear on power-down timer overflow.
// - Wake clear to sleep when key low.
// - Wake clear to ramp up when key high.
// - Wake is OR of pin, bus and engine-off timer wakes.
module eosc_top (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic KEY_HIGH_IN,
  input wire eosc_pkg::eosc_wake_t WAKE_IN,
  input wire eosc_pkg::eosc_timer_t TIMER_IN,
  input wire logic ECU_5V_SUPPLY_OK_IN,
  input wire logic BATTERY_PIN_OK_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [2:0] STATE_OUT,
  output eosc_pkg::eosc_ctrl_t CTRL_OUT
);

  eosc_pkg::eosc_regs_t cur_r;
  eosc_pkg::eosc_regs_t cur_nxt;
  logic wake;
  logic key_low;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] status_word;

  assign wake = WAKE_IN.internal_pin_wake | WAKE_IN.bus_wake | WAKE_IN.engine_off_timer_wake;
  assign key_low = ~KEY_HIGH_IN;

  // Zero-wait APB slave; the access phase always completes in one cycle
  assign addr_ok = (PADDR_IN == eosc_pkg::OPERATION_CONFIG_REG_OFS) ||
                   (PADDR_IN == eosc_pkg::COMMAND_REG_OFS) ||
                   (PADDR_IN == eosc_pkg::OPERATION_STATUS_REG_OFS);
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & addr_ok;
  assign rd_en = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
  assign PRDATA_OUT = cur_r.prdata;
  assign STATE_OUT = cur_r.state;
  assign CTRL_OUT = cur_r.ctrl;

  always_comb begin
    status_word = eosc_pkg::RDATA_ZERO;
    status_word[eosc_pkg::STS_STATE_LSB +: 3] = cur_r.state;
    status_word[eosc_pkg::STS_OM_BIT] = (cur_r.state == eosc_pkg::ST_AFTERRUN);
    status_word[eosc_pkg::STS_WAKE_BIT] = wake;
  end

  always_comb begin
    cur_nxt = cur_r;

    // Read data is captured in the setup cycle so it is stable in the access phase
    if (rd_en) begin
      case (PADDR_IN)
        eosc_pkg::OPERATION_CONFIG_REG_OFS: begin
          cur_nxt.prdata = eosc_pkg::RDATA_ZERO;
          cur_nxt.prdata[eosc_pkg::CFG_AE_BIT] = cur_r.afterrun_enable;
          cur_nxt.prdata[eosc_pkg::CFG_AR_BIT] = cur_r.afterrun_reset_enable;
          cur_nxt.prdata[eosc_pkg::CFG_MR_BIT] = cur_r.main_relay_status_bit;
        end
        eosc_pkg::COMMAND_REG_OFS: begin
          cur_nxt.prdata = eosc_pkg::RDATA_ZERO;
          cur_nxt.prdata[eosc_pkg::CMD_WAKE_CLEAR_BIT_BIT] = cur_r.wake_clear_bit;
        end
        eosc_pkg::OPERATION_STATUS_REG_OFS: begin
          cur_nxt.prdata = status_word;
        end
        default: begin
          cur_nxt.prdata = eosc_pkg::RDATA_ZERO;
        end
      endcase
    end

    if (wr_en) begin
      case (PADDR_IN)
        eosc_pkg::OPERATION_CONFIG_REG_OFS: begin
          // software clears enable to shut down
          cur_nxt.afterrun_enable = PWDATA_IN[eosc_pkg::CFG_AE_BIT];
          cur_nxt.afterrun_reset_enable = PWDATA_IN[eosc_pkg::CFG_AR_BIT];
          cur_nxt.main_relay_status_bit = PWDATA_IN[eosc_pkg::CFG_MR_BIT];
        end
        eosc_pkg::COMMAND_REG_OFS: begin
          cur_nxt.wake_clear_bit = PWDATA_IN[eosc_pkg::CMD_WAKE_CLEAR_BIT_BIT];
        end
        default: begin
        end
      endcase
    end

    case (cur_r.state)
      eosc_pkg::ST_SLEEP: begin
        if (KEY_HIGH_IN || wake) begin
          cur_nxt.state = eosc_pkg::ST_RAMP_UP;
        end
      end
      eosc_pkg::ST_RAMP_UP: begin
        if (key_low && !wake) begin
          cur_nxt.state = eosc_pkg::ST_SLEEP;
        end else if (key_low && wake && TIMER_IN.ramp_timer_overflow) begin
          cur_nxt.state = eosc_pkg::ST_WAKE_CLR;
        end else if (ECU_5V_SUPPLY_OK_IN) begin
          cur_nxt.state = eosc_pkg::ST_NORMAL;
        end
      end
      eosc_pkg::ST_NORMAL: begin
        // shut off needs key low here
        if (key_low && (TIMER_IN.powerdown_counter_overflow || TIMER_IN.secure_shutoff_timer_expired)) begin
          cur_nxt.state = eosc_pkg::ST_POWERDOWN;
        end else if (key_low && cur_r.afterrun_enable) begin
          cur_nxt.state = eosc_pkg::ST_AFTERRUN;
        end else if (key_low && !wake) begin
          cur_nxt.state = eosc_pkg::ST_SLEEP;
        end
      end
      eosc_pkg::ST_AFTERRUN: begin
        if (TIMER_IN.powerdown_counter_overflow || TIMER_IN.secure_shutoff_timer_expired) begin
          cur_nxt.state = eosc_pkg::ST_POWERDOWN;
        end else if (KEY_HIGH_IN && cur_r.afterrun_reset_enable) begin
          cur_nxt.state = eosc_pkg::ST_AR_RESET;
        end else if (KEY_HIGH_IN) begin
          cur_nxt.state = eosc_pkg::ST_NORMAL;
        end else if (!cur_r.afterrun_enable && !wake) begin
          cur_nxt.state = eosc_pkg::ST_SLEEP;
        end
      end
      eosc_pkg::ST_AR_RESET: begin
        cur_nxt.state = eosc_pkg::ST_NORMAL;
      end
      eosc_pkg::ST_POWERDOWN: begin
        if (TIMER_IN.powerdown_timer_overflow) begin
          cur_nxt.state = eosc_pkg::ST_WAKE_CLR;
        end
      end
      eosc_pkg::ST_WAKE_CLR: begin
        if (key_low) begin
          cur_nxt.state = eosc_pkg::ST_SLEEP;
        end else begin
          cur_nxt.state = eosc_pkg::ST_RAMP_UP;
        end
      end
      default: begin
        cur_nxt.state = eosc_pkg::ST_SLEEP;
      end
    endcase

    // Relay state is frozen on the way into power-down
    if (cur_r.state != eosc_pkg::ST_POWERDOWN) begin
      cur_nxt.relay_hold = cur_r.ctrl.main_relay_on;
    end

    // Outputs registered from the next state so they align with STATE_OUT
    cur_nxt.ctrl = '0;
    cur_nxt.ctrl.wake_clear_mode = cur_nxt.wake_clear_bit;
    cur_nxt.ctrl.ar_reset = (cur_nxt.state == eosc_pkg::ST_AR_RESET);
    case (cur_nxt.state)
      eosc_pkg::ST_SLEEP: begin
        cur_nxt.ctrl.main_relay_on = 1'b0;
      end
      eosc_pkg::ST_RAMP_UP: begin
        cur_nxt.ctrl.pre_reg_en = 1'b1;
        cur_nxt.ctrl.ecu_supply_en = 1'b1;
        cur_nxt.ctrl.tracker_en = 1'b1;
        cur_nxt.ctrl.main_relay_on = BATTERY_PIN_OK_IN;
        cur_nxt.ctrl.ramp_timer_run = key_low;
      end
      eosc_pkg::ST_NORMAL, eosc_pkg::ST_AFTERRUN, eosc_pkg::ST_AR_RESET: begin
        cur_nxt.ctrl.pre_reg_en = 1'b1;
        cur_nxt.ctrl.ecu_supply_en = 1'b1;
        cur_nxt.ctrl.tracker_en = 1'b1;
        cur_nxt.ctrl.ext_func_en = 1'b1;
        cur_nxt.ctrl.main_relay_on = BATTERY_PIN_OK_IN | cur_nxt.main_relay_status_bit;
      end
      eosc_pkg::ST_POWERDOWN: begin
        cur_nxt.ctrl.pre_reg_en = 1'b1;
        cur_nxt.ctrl.pd_timer_run = 1'b1;
        cur_nxt.ctrl.main_relay_on = cur_nxt.relay_hold;
      end
      eosc_pkg::ST_WAKE_CLR: begin
        cur_nxt.ctrl.pre_reg_en = 1'b1;
        cur_nxt.ctrl.wake_clear = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // power-on reset clears everything except wake_clear_bit, which resets to 1; sleep then exits by key or wake
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cur_r <= '{state: eosc_pkg::ST_SLEEP,
                 afterrun_enable: eosc_pkg::CFG_RESET[eosc_pkg::CFG_AE_BIT],
                 afterrun_reset_enable: eosc_pkg::CFG_RESET[eosc_pkg::CFG_AR_BIT],
                 main_relay_status_bit: eosc_pkg::CFG_RESET[eosc_pkg::CFG_MR_BIT],
                 wake_clear_bit: eosc_pkg::CMD_WAKE_CLEAR_BIT_RESET,
                 relay_hold: 1'b0,
                 prdata: eosc_pkg::RDATA_ZERO,
                 ctrl: '0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

endmodule

// *** verif/eosc_partner.sv ***
// Far side model: wake sources and the ECU 5V supply ramp.
// Assumes STATE_OUT and CTRL_OUT of the sequencer on the same clock.
`timescale 1ns/100ps
module eosc_partner (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] wake_set_in,
  input wire logic ramp_ok_in,
  input wire logic [2:0] state_in,
  input wire eosc_pkg::eosc_ctrl_t ctrl_in,
  output eosc_pkg::eosc_wake_t wake_out,
  output logic supply_ok_out
);
  logic [1:0] cnt_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_out <= 3'h0;
      cnt_r <= 2'h0;
    end else begin
      wake_out <= ctrl_in.wake_clear ? 3'h0 : wake_out | wake_set_in;
      if (state_in inside {eosc_pkg::ST_SLEEP, eosc_pkg::ST_POWERDOWN, eosc_pkg::ST_WAKE_CLR})
        cnt_r <= 2'h0;
      else if (cnt_r != 2'h3)
        cnt_r <= cnt_r + 2'h1;
    end
  end
  assign supply_ok_out = ramp_ok_in && cnt_r == 2'h3;
endmodule

// *** verif/eosc_top_assertions.sv ***
// Port checks of the operation state sequencer.
// Assumes binding onto eosc_top; one clock domain.
`timescale 1ns/100ps
module eosc_top_assertions (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic KEY_HIGH_IN,
  input wire eosc_pkg::eosc_wake_t WAKE_IN,
  input wire eosc_pkg::eosc_timer_t TIMER_IN,
  input wire logic ECU_5V_SUPPLY_OK_IN,
  input wire logic [2:0] STATE_OUT,
  input wire eosc_pkg::eosc_ctrl_t CTRL_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic wk;
  logic pdx;
  assign wk = |WAKE_IN;
  assign pdx = TIMER_IN.powerdown_counter_overflow || TIMER_IN.secure_shutoff_timer_expired;
  sequence s_arr;
    STATE_OUT == eosc_pkg::ST_AR_RESET ##1 STATE_OUT == eosc_pkg::ST_NORMAL;
  endsequence
  a_sleep_wake: assert property (STATE_OUT == eosc_pkg::ST_SLEEP && (KEY_HIGH_IN || wk)
    |=> STATE_OUT == eosc_pkg::ST_RAMP_UP) else $error("sleep did not wake");
  a_ramp_drop: assert property (STATE_OUT == eosc_pkg::ST_RAMP_UP && !KEY_HIGH_IN && !wk
    |=> STATE_OUT == eosc_pkg::ST_SLEEP) else $error("ramp did not drop");
  a_ramp_clear: assert property (STATE_OUT == eosc_pkg::ST_RAMP_UP && !KEY_HIGH_IN && wk
    && TIMER_IN.ramp_timer_overflow |=> STATE_OUT == eosc_pkg::ST_WAKE_CLR) else $error("no wake clear");
  a_ramp_norm: assert property (STATE_OUT == eosc_pkg::ST_RAMP_UP && ECU_5V_SUPPLY_OK_IN
    && (KEY_HIGH_IN || wk && !TIMER_IN.ramp_timer_overflow) |=> STATE_OUT == eosc_pkg::ST_NORMAL)
    else $error("ramp not normal");
  a_ar_pd: assert property (STATE_OUT == eosc_pkg::ST_AFTERRUN && pdx
    |=> STATE_OUT == eosc_pkg::ST_POWERDOWN) else $error("afterrun no power-down");
  a_norm_pd: assert property (STATE_OUT == eosc_pkg::ST_NORMAL && pdx && !KEY_HIGH_IN
    |=> STATE_OUT == eosc_pkg::ST_POWERDOWN) else $error("normal no power-down");
  a_arr_once: assert property (STATE_OUT == eosc_pkg::ST_AR_RESET |-> s_arr)
    else $error("afterrun reset too long");
  a_pd_clear: assert property (STATE_OUT == eosc_pkg::ST_POWERDOWN && TIMER_IN.powerdown_timer_overflow
    |=> STATE_OUT == eosc_pkg::ST_WAKE_CLR) else $error("power-down stuck");
  a_clr_exit: assert property (STATE_OUT == eosc_pkg::ST_WAKE_CLR |=> STATE_OUT ==
    ($past(KEY_HIGH_IN) ? eosc_pkg::ST_RAMP_UP : eosc_pkg::ST_SLEEP)) else $error("wake clear exit");
  a_sleep_off: assert property (STATE_OUT == eosc_pkg::ST_SLEEP |-> !CTRL_OUT.main_relay_on
    && !CTRL_OUT.ecu_supply_en) else $error("sleep supplied");
  a_clr_pulse: assert property (STATE_OUT == eosc_pkg::ST_WAKE_CLR |-> CTRL_OUT.wake_clear)
    else $error("no wake clear pulse");
  a_pd_off: assert property (STATE_OUT == eosc_pkg::ST_POWERDOWN |-> CTRL_OUT.pd_timer_run
    && !CTRL_OUT.ecu_supply_en && !CTRL_OUT.tracker_en && !CTRL_OUT.ext_func_en) else $error("power-down supplied");
endmodule
bind eosc_top eosc_top_assertions u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .KEY_HIGH_IN(KEY_HIGH_IN),
  .WAKE_IN(WAKE_IN), .TIMER_IN(TIMER_IN), .ECU_5V_SUPPLY_OK_IN(ECU_5V_SUPPLY_OK_IN),
  .STATE_OUT(STATE_OUT), .CTRL_OUT(CTRL_OUT));

// *** verif/eosc_top_tb.sv ***
// Self-checking bench of the operation state sequencer.
// Assumes eosc_top, eosc_partner and the bound checker compiled first.
`timescale 1ns/100ps
module eosc_top_tb;
  logic c = 0, r = 1, key = 0, sen = 0, psel = 0, pen = 0, pw = 0, battery_pin = 1, prdy, perr, er, sok;
  logic [2:0] wset = 3'h0, st, v;
  logic [7:0] pa = 8'h00;
  logic [31:0] pd = 32'h0, prd, rd, seed = 32'h74DC23A6;
  eosc_pkg::eosc_timer_t tmr = 4'h0;
  eosc_pkg::eosc_wake_t wk;
  eosc_pkg::eosc_ctrl_t ctl;
  int fails = 0, compares = 0;
  initial forever #12.5 c = ~c;
  eosc_top uut (.CORE_CLK_IN(c), .RST_IN(r), .KEY_HIGH_IN(key), .WAKE_IN(wk), .TIMER_IN(tmr),
    .ECU_5V_SUPPLY_OK_IN(sok), .BATTERY_PIN_OK_IN(battery_pin), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .STATE_OUT(st), .CTRL_OUT(ctl));
  eosc_partner far (.clk_in(c), .rst_in(r), .wake_set_in(wset), .ramp_ok_in(sen), .state_in(st),
    .ctrl_in(ctl), .wake_out(wk), .supply_ok_out(sok));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] sts(input logic [2:0] s, input logic w);
    return {26'h0, w, s == eosc_pkg::ST_AFTERRUN, 1'b0, s};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stp(input logic [2:0] e);
    @(posedge c);
    #1;
    chk({29'h0, st}, {29'h0, e});
  endtask
  task automatic ks(input logic k, input logic [2:0] e);
    @(posedge c);
    key <= k;
    stp(e);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge c);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge c);
    pen <= 1'b1;
    do begin
      @(posedge c);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic done(input string n);
    $display("test %0s done", n);
  endtask
  task automatic wrap_up;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge c);
    r <= 1'b0;
    #2;
    chk({22'h0, ctl}, 32'h0);
    apb(1'b0, eosc_pkg::OPERATION_CONFIG_REG_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, eosc_pkg::COMMAND_REG_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    done("regs");
    for (int i = 0; i < 11; i++) begin
      seed = lfsr(seed);
      v = i < 3 ? 3'h1 << i : seed[2:0];
      @(posedge c);
      wset <= v;
      tmr <= 4'h0;
      battery_pin <= seed[3];
      @(posedge c);
      wset <= 3'h0;
      stp(v != 3'h0 ? eosc_pkg::ST_RAMP_UP : eosc_pkg::ST_SLEEP);
      if (v != 3'h0) begin
        chk({22'h0, ctl} & 32'h3C8, {22'h0, battery_pin, 3'h7, 2'h0, 1'b1, 3'h0});
        @(posedge c);
        tmr <= 4'h8;
        stp(eosc_pkg::ST_WAKE_CLR);
        chk({22'h0, ctl} & 32'h6, 32'h6);
        stp(eosc_pkg::ST_SLEEP);
      end
    end
    done("wake");
    @(posedge c);
    tmr <= 4'h0;
    sen <= 1'b1;
    battery_pin <= 1'b1;
    ks(1'b1, eosc_pkg::ST_RAMP_UP);
    stp(eosc_pkg::ST_RAMP_UP);
    repeat (2) stp(eosc_pkg::ST_RAMP_UP);
    stp(eosc_pkg::ST_NORMAL);
    chk({22'h0, ctl} & 32'h3A0, 32'h3A0);
    ks(1'b0, eosc_pkg::ST_SLEEP);
    ks(1'b1, eosc_pkg::ST_RAMP_UP);
    repeat (3) stp(eosc_pkg::ST_RAMP_UP);
    stp(eosc_pkg::ST_NORMAL);
    apb(1'b1, eosc_pkg::OPERATION_CONFIG_REG_OFS, 32'h3);
    ks(1'b0, eosc_pkg::ST_AFTERRUN);
    chk({22'h0, ctl} & 32'h120, 32'h120);
    apb(1'b0, eosc_pkg::OPERATION_CONFIG_REG_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, eosc_pkg::OPERATION_STATUS_REG_OFS, 32'h0);
    chk(rd, sts(eosc_pkg::ST_AFTERRUN, 1'b0));
    ks(1'b1, eosc_pkg::ST_AR_RESET);
    stp(eosc_pkg::ST_NORMAL);
    apb(1'b1, eosc_pkg::OPERATION_CONFIG_REG_OFS, 32'h1);
    ks(1'b0, eosc_pkg::ST_AFTERRUN);
    ks(1'b1, eosc_pkg::ST_NORMAL);
    apb(1'b1, eosc_pkg::COMMAND_REG_OFS, 32'h0);
    done("afterrun");
    @(posedge c);
    tmr <= 4'h4;
    ks(1'b0, eosc_pkg::ST_POWERDOWN);
    chk({22'h0, ctl} & 32'h3B0, 32'h210);
    @(posedge c);
    tmr <= 4'h1;
    key <= 1'b1;
    stp(eosc_pkg::ST_WAKE_CLR);
    stp(eosc_pkg::ST_RAMP_UP);
    repeat (3) stp(eosc_pkg::ST_RAMP_UP);
    stp(eosc_pkg::ST_NORMAL);
    ks(1'b0, eosc_pkg::ST_AFTERRUN);
    @(posedge c);
    tmr <= 4'h2;
    stp(eosc_pkg::ST_POWERDOWN);
    @(posedge c);
    tmr <= 4'h1;
    stp(eosc_pkg::ST_WAKE_CLR);
    chk({22'h0, ctl} & 32'h6, 32'h4);
    stp(eosc_pkg::ST_SLEEP);
    done("powerdown");
    @(posedge c);
    tmr <= 4'h0;
    sen <= 1'b0;
    ks(1'b1, eosc_pkg::ST_RAMP_UP);
    ks(1'b0, eosc_pkg::ST_SLEEP);
    ks(1'b1, eosc_pkg::ST_RAMP_UP);
    @(posedge c);
    r <= 1'b1;
    #2;
    chk({29'h0, st}, 32'h0);
    @(posedge c);
    r <= 1'b0;
    stp(eosc_pkg::ST_RAMP_UP);
    done("reset");
    wrap_up;
  end
endmodule
